// ===== bench/piu_dp_master.sv
// Behavioural fieldbus master sending parameter and data telegrams.
module piu_dp_master (
    // Clock
    input  wire logic           clock_i,
    // Telegram events
    output piu_pkg::piu_prm_t   prm_o,
    output logic                dx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        prm_o = '0;
        dx_o  = 1'b0;
    end
    // ======
    // Telegrams
    // The first block opens the connection before any data telegram; later ones re-parameterise.
    task automatic send_prm(input logic [7:0] b);
        prm_o = '{valid: 1'b1, byte9: b};
        @(posedge clock_i);
        #1;
        prm_o = '{valid: 1'b0, byte9: ~b};
    endtask
    task automatic send_dx();
        dx_o = 1'b1;
        @(posedge clock_i);
        #1;
        dx_o = 1'b0;
    endtask
endmodule

// ===== bench/piu_scheduler_properties.sv
// Port checks of the process image update scheduler.
`include "piu_defs.svh"

module piu_scheduler_chk #(
    parameter int SVC_GAP_NS  = `PIU_SVC_GAP_NS,
    parameter int FAST_GAP_NS = `PIU_FAST_GAP_NS
) (
    // Watched ports
    input wire logic                     clock_i,
    input wire logic                     reset_i,
    input wire piu_pkg::piu_prm_t        prm_i,
    input wire logic                     dx_done_i,
    input wire piu_pkg::piu_slave_t      slave_i,
    input wire logic                     cycle_done_i,
    input wire piu_pkg::piu_chan_t       chan_i,
    input wire logic                     cycle_start_o,
    input wire logic                     cycle_busy_o,
    input wire logic                     service_en_o,
    input wire logic                     sync_mode_o,
    input wire logic                     fast_mode_o,
    input wire logic                     prm_ok_o,
    input wire logic [31:0]              est_cycle_ns_o,
    input wire logic [`PIU_BUDGET_W-1:0] dp_budget_ns_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SL = SVC_GAP_NS / 20;
    localparam int FL = FAST_GAP_NS / 20;
    int   gap_q;
    logic pend_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ======
    // Helpers
    // A new parameter block restarts the gap count, so mode changes never look like late starts.
    always_ff @(posedge clock_i) begin
        gap_q  <= (reset_i || prm_i.valid || !service_en_o) ? 0 : gap_q + 1;
        pend_q <= (reset_i || !sync_mode_o || (prm_i.valid && !prm_i.byte9[6])) ? 1'b0 :
                  (sync_mode_o && cycle_busy_o && dx_done_i) ? 1'b1 :
                  cycle_start_o ? 1'b0 : pend_q;
    end
    function automatic int est_ns(input piu_pkg::piu_chan_t c);
        int n = c.dig_out + c.dig_in;
        return (n <= 4) ? 150000 : 150000 + (n - 4) * 3333;
    endfunction
    sequence s_end;
        ##1 (!cycle_busy_o && service_en_o);
    endsequence
    sequence s_restart;
        ##1 !cycle_busy_o ##1 cycle_start_o;
    endsequence
    // ======
    // Assertions
    AST_MODE: assert property (prm_i.valid |=> prm_ok_o && sync_mode_o == $past(prm_i.byte9[6]))
        else $error("mode select wrong");
    AST_FAST: assert property (prm_i.valid |=>
        fast_mode_o == ($past(prm_i.byte9[4]) && !$past(prm_i.byte9[6])))
        else $error("fast mode wrong");
    AST_NOFAST: assert property (sync_mode_o |-> !fast_mode_o)
        else $error("fast mode in sync");
    AST_SYNC: assert property (sync_mode_o && service_en_o && dx_done_i && $past(prm_ok_o)
        && !prm_i.valid |=> cycle_start_o) else $error("no start after telegram");
    AST_PULSE: assert property (cycle_start_o |=> !cycle_start_o && cycle_busy_o && !service_en_o)
        else $error("start pulse wrong");
    AST_END: assert property (cycle_busy_o && cycle_done_i && !cycle_start_o |-> s_end)
        else $error("cycle end wrong");
    AST_RESTART: assert property (pend_q && cycle_busy_o && cycle_done_i && !cycle_start_o
        |-> s_restart) else $error("pending trigger lost");
    AST_GAP_MIN: assert property (cycle_start_o && !sync_mode_o
        |-> gap_q >= (fast_mode_o ? FL : SL)) else $error("free-run start early");
    AST_GAP_MAX: assert property (prm_ok_o && !sync_mode_o |-> gap_q <= SL + 2)
        else $error("free-run start late");
    AST_CLR: assert property (slave_i.clear |=> dp_budget_ns_o == 191000)
        else $error("budget clear wrong");
    AST_ADD: assert property (slave_i.add && !slave_i.clear |=> dp_budget_ns_o ==
        $past(dp_budget_ns_o) + 24000 + 920 * $past(slave_i.io_bytes)) else $error("budget add wrong");
    AST_EST: assert property (1'b1 |=> est_cycle_ns_o == est_ns($past(chan_i)))
        else $error("cycle estimate wrong");
endmodule

bind piu_scheduler piu_scheduler_chk #(.SVC_GAP_NS(SVC_GAP_NS), .FAST_GAP_NS(FAST_GAP_NS))
    u_piu_scheduler_chk (.clock_i, .reset_i, .prm_i, .dx_done_i, .slave_i, .cycle_done_i,
    .chan_i, .cycle_start_o, .cycle_busy_o, .service_en_o, .sync_mode_o, .fast_mode_o,
    .prm_ok_o, .est_cycle_ns_o, .dp_budget_ns_o);

// ===== bench/piu_scheduler_tb_top.sv
// Self-checking bench of the process image update scheduler.
module piu_scheduler_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import piu_pkg::*;
    localparam int SG = 2000;
    localparam int FG = 200;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        done    = 1'b0;
    piu_prm_t    prm;
    logic        dx;
    piu_slave_t  slave   = '0;
    piu_chan_t   chan    = '0;
    logic        start, busy, svc, sync, fast, pok;
    logic [31:0] last, est, bud;
    int          bad_count    = 0;
    int          total_checks = 0;
    int          eb, n, i;
    logic [7:0]  rnd       = 8'h53;
    logic [7:0]  modes [3] = '{8'h10, 8'h50, 8'h40};

    always #10 clock_i = ~clock_i;

    piu_dp_master u_piu_dp_master (.clock_i(clock_i), .prm_o(prm), .dx_o(dx));
    piu_scheduler #(.SVC_GAP_NS(SG), .FAST_GAP_NS(FG)) u_piu_scheduler (
        .clock_i(clock_i), .reset_i(reset_i), .prm_i(prm), .dx_done_i(dx), .slave_i(slave),
        .cycle_done_i(done), .chan_i(chan), .cycle_start_o(start), .cycle_busy_o(busy),
        .service_en_o(svc), .sync_mode_o(sync), .fast_mode_o(fast), .prm_ok_o(pok),
        .last_cycle_clk_o(last), .est_cycle_ns_o(est), .dp_budget_ns_o(bud));

    // ======
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // In sync mode a telegram is sent first, since the scheduler would otherwise wait forever.
    task automatic wait_start();
        if (sync) u_piu_dp_master.send_dx();
        n = 0;
        while (start !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        chk("start", start, 1);
        chk("wait", n <= (sync ? 0 : (fast ? FG : SG) / 20 + 2), 1);
    endtask
    task automatic end_cycle(input int k, input int e);
        repeat (k) tick();
        done = 1'b1;
        tick();
        done = 1'b0;
        chk("busy", busy, 0);
        chk("service", svc, 1);
        chk("last", last, e);
    endtask

    // ======
    // Sequence
    initial begin
        repeat (16) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        chk("est", est, 150000);
        chk("budget", bud, 191000);
        eb = 191000;
        for (i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            slave = '{clear: (i == 4), add: 1'b1, io_bytes: rnd};
            chan = '{dig_out: {5'h0, rnd[2:0]}, dig_in: (i[0] ? 8'h0 : {2'h0, rnd[7:2]})};
            eb = (i == 4) ? 191000 : eb + 24000 + 920 * rnd;
            n = chan.dig_out + chan.dig_in;
            tick();
            chk("budget", bud, eb);
            chk("est", est, (n <= 4) ? 150000 : 150000 + (n - 4) * 3333);
        end
        slave = '0;
        u_piu_dp_master.send_dx();
        chk("start", start, 0);
        u_piu_dp_master.send_prm(8'h00);
        chk("prm_ok", pok, 1);
        u_piu_dp_master.send_dx();
        chk("start", start, 0);
        // A telegram in the free-run gap must not pull the next cycle forward.
        tick();
        u_piu_dp_master.send_dx();
        chk("start", start, 0);
        wait_start();
        end_cycle(3, 3);
        // The middle byte asks for fast mode together with synchronous updating.
        for (i = 0; i < 3; i++) begin
            wait_start();
            u_piu_dp_master.send_prm(modes[i]);
            chk("sync", sync, modes[i][6]);
            chk("fast", fast, modes[i][4] & ~modes[i][6]);
            end_cycle(2, 3);
        end
        wait_start();
        tick();
        u_piu_dp_master.send_dx();
        end_cycle(0, 2);
        tick();
        chk("restart", start, 1);
        tick();
        chk("pulse", start, 0);
        end_cycle(1, 2);
        // A stray done between cycles must not touch the record of the last cycle.
        tick();
        done = 1'b1;
        tick();
        done = 1'b0;
        chk("busy", busy, 0);
        chk("last", last, 2);
        // A second reset must forget the parameters, so telegrams are ignored again.
        reset_i = 1'b1;
        tick();
        reset_i = 1'b0;
        chk("prm_ok", pok, 0);
        chk("budget", bud, 191000);
        chk("last", last, 0);
        u_piu_dp_master.send_dx();
        chk("start", start, 0);
        tick();
        chk("busy", busy, 0);
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        bad_count++;
        print_verdict();
    end
endmodule

// ===== hw/piu_budget.sv
// Accumulator of the fieldbus reaction-time budget over all slaves.
`include "piu_defs.svh"

module piu_budget (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     reset_i,
    // Slave entries
    input  wire piu_pkg::piu_slave_t      slave_i,
    // Result
    output logic [`PIU_BUDGET_W-1:0]      budget_ns_o
);
    import piu_pkg::*;

    piu_bud_t                  q;
    piu_bud_t                  d;
    logic [`PIU_BUDGET_W-1:0]  slave_ns;

    // Each slave costs B plus its byte count times the per-byte time.
    always_comb begin
        slave_ns = `PIU_DP_B_NS + ({24'h0, slave_i.io_bytes} * `PIU_DP_PER_BYTE_TRANSFER_TIME_NS);
        d = q;
        if (slave_i.clear) begin
            d.sum = `PIU_DP_A_NS;
        end else if (slave_i.add) begin
            d.sum = q.sum + slave_ns;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            q.sum <= `PIU_DP_A_NS;
        end else begin
            q <= d;
        end
    end

    assign budget_ns_o = q.sum;

endmodule

// ===== hw/piu_scheduler.sv
// Scheduler that decides when the internal terminal bus cycle runs.
//
// Summary of operation
// - Synchronous mode starts one terminal bus cycle per completed Data_Exchange.
// - Free-run mode starts terminal bus cycles on its own, ignoring Data_Exchange.
// - Bit 6 of user parameter byte 9 selects free-run or synchronous.
// - Bit 4 of byte 9 enables fast-free-run: bus cycles first, services later.
// - Fast-free-run is only honoured in free-run mode, never in synchronous mode.
// - Fieldbus budget is A plus, per slave, B plus bytes times per-byte time.
// - Terminal bus cycle time grows with channel count from 150 us, reaching 349.98 us at 64 channels, with no upper limit.
`include "piu_defs.svh"

module piu_scheduler #(
    parameter int SVC_GAP_NS  = `PIU_SVC_GAP_NS,
    parameter int FAST_GAP_NS = `PIU_FAST_GAP_NS
) (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     reset_i,
    // Fieldbus protocol side
    input  wire piu_pkg::piu_prm_t        prm_i,
    input  wire logic                     dx_done_i,
    input  wire piu_pkg::piu_slave_t      slave_i,
    // Terminal bus engine side
    input  wire logic                     cycle_done_i,
    input  wire piu_pkg::piu_chan_t       chan_i,
    output logic                          cycle_start_o,
    output logic                          cycle_busy_o,
    // Acyclic and configuration service side
    output logic                          service_en_o,
    // Status
    output logic                          sync_mode_o,
    output logic                          fast_mode_o,
    output logic                          prm_ok_o,
    output logic [`PIU_CNT_W-1:0]         last_cycle_clk_o,
    output logic [31:0]                   est_cycle_ns_o,
    output logic [`PIU_BUDGET_W-1:0]      dp_budget_ns_o
);
    import piu_pkg::*;

    // ======================================================================
    // Derived counts
    // ======================================================================
    localparam int SVC_GAP_CLK  = SVC_GAP_NS / `PIU_CLK_NS;
    localparam int FAST_GAP_CLK = FAST_GAP_NS / `PIU_CLK_NS;
    localparam logic [31:0] TB_SLOPE_NS =
        (`PIU_TB_TOP_NS - `PIU_TB_BASE_NS) / 32'(`PIU_TB_TOP_CH - `PIU_TB_BASE_CH);

    // A fast gap longer than the normal one would make fast mode slower.
    if (FAST_GAP_CLK < 1 || SVC_GAP_CLK < FAST_GAP_CLK) begin : g_bad_gap
        $error("piu_scheduler: gap parameters out of range");
    end

    piu_reg_t              q;
    piu_reg_t              d;
    logic [`PIU_CNT_W-1:0] gap_lim;
    logic [8:0]            chans;
    logic                  sync_sel;

    // ======================================================================
    // Fieldbus reaction budget
    // ======================================================================
    piu_budget u_budget (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .slave_i     (slave_i),
        .budget_ns_o (dp_budget_ns_o)
    );

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        d        = q;
        sync_sel = prm_i.byte9[`PIU_SYNC_BIT];
        chans    = {1'b0, chan_i.dig_out} + {1'b0, chan_i.dig_in};

        // The parameter block is expected once at connection set-up; a
        // repeated one simply reloads the mode for the following cycles.
        if (prm_i.valid) begin
            d.prm_ok    = 1'b1;
            d.sync_mode = sync_sel;
            d.fast_mode = prm_i.byte9[`PIU_FAST_BIT] & ~sync_sel;
        end

        // Small configurations still cost the fixed base time.
        if (chans <= `PIU_TB_BASE_CH) begin
            d.est_ns = `PIU_TB_BASE_NS;
        end else begin
            d.est_ns = `PIU_TB_BASE_NS
                     + (32'(chans - `PIU_TB_BASE_CH) * TB_SLOPE_NS);
        end

        gap_lim = q.fast_mode ? `PIU_CNT_W'(FAST_GAP_CLK)
                              : `PIU_CNT_W'(SVC_GAP_CLK);

        unique case (q.st)
            PIU_ST_IDLE: begin
                // No cycles until the mode is known.
                if (q.prm_ok) begin
                    d.st      = PIU_ST_GAP;
                    d.gap_cnt = '0;
                end
            end
            PIU_ST_GAP: begin
                d.gap_cnt = q.gap_cnt + `PIU_CNT_W'(1);
                if (q.sync_mode) begin
                    if (dx_done_i || q.pend) begin
                        d.st   = PIU_ST_START;
                        d.pend = 1'b0;
                    end
                end else if (q.gap_cnt >= gap_lim - `PIU_CNT_W'(1)) begin
                    d.st = PIU_ST_START;
                end
            end
            PIU_ST_START: begin
                d.st      = PIU_ST_RUN;
                d.run_cnt = '0;
                if (q.sync_mode && dx_done_i) begin
                    d.pend = 1'b1;
                end
            end
            PIU_ST_RUN: begin
                d.run_cnt = q.run_cnt + `PIU_CNT_W'(1);
                if (q.sync_mode && dx_done_i) begin
                    d.pend = 1'b1;
                end
                if (cycle_done_i) begin
                    d.last_run = q.run_cnt + `PIU_CNT_W'(1);
                    d.st       = PIU_ST_GAP;
                    d.gap_cnt  = '0;
                end
            end
        endcase

        // Free-run never keeps a stale synchronous trigger.
        if (!d.sync_mode) begin
            d.pend = 1'b0;
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            q.st        <= PIU_ST_IDLE;
            q.prm_ok    <= 1'b0;
            q.sync_mode <= 1'b0;
            q.fast_mode <= 1'b0;
            q.pend      <= 1'b0;
            q.gap_cnt   <= '0;
            q.run_cnt   <= '0;
            q.last_run  <= '0;
            q.est_ns    <= `PIU_TB_BASE_NS;
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    // Services get the bus only while no cycle runs (idle and gap), so fast mode shortens them.
    assign cycle_start_o    = (q.st == PIU_ST_START);
    assign cycle_busy_o     = (q.st == PIU_ST_START) || (q.st == PIU_ST_RUN);
    assign service_en_o     = (q.st == PIU_ST_GAP) || (q.st == PIU_ST_IDLE);
    assign sync_mode_o      = q.sync_mode;
    assign fast_mode_o      = q.fast_mode;
    assign prm_ok_o         = q.prm_ok;
    assign last_cycle_clk_o = q.last_run;
    assign est_cycle_ns_o   = q.est_ns;

endmodule

// ===== pkg/piu_defs.svh
// Constants of the process image update scheduler.
`ifndef PIU_DEFS_SVH
`define PIU_DEFS_SVH

// ==========================================================================
// User parameter byte 9 fields
// ==========================================================================
`define PIU_PRM_BYTE_IDX   9
`define PIU_SYNC_BIT       6
`define PIU_FAST_BIT       4

// ==========================================================================
// Clock
// ==========================================================================
`define PIU_CLK_NS         20

// ==========================================================================
// Fieldbus reaction budget at 12 MBaud, in ns
// ==========================================================================
`define PIU_DP_A_NS        32'd191000
`define PIU_DP_B_NS        32'd24000
`define PIU_DP_PER_BYTE_TRANSFER_TIME_NS    32'd920
`define PIU_BUDGET_W       32

// ==========================================================================
// Terminal bus cycle estimate, in ns and channels
// ==========================================================================
`define PIU_TB_BASE_NS     32'd150000
`define PIU_TB_BASE_CH     9'd4
`define PIU_TB_TOP_NS      32'd350000
`define PIU_TB_TOP_CH      9'd64

// ==========================================================================
// Scheduling gaps between free-run cycles, in ns
// ==========================================================================
`define PIU_SVC_GAP_NS     100000
`define PIU_FAST_GAP_NS    10000
`define PIU_CNT_W          32

`endif

// ===== pkg/piu_pkg.sv
// Types of the process image update scheduler.
`include "piu_defs.svh"

package piu_pkg;

    // ======================================================================
    // Scheduler states
    // ======================================================================
    typedef enum logic [3:0] {
        PIU_ST_IDLE  = 4'h1,
        PIU_ST_GAP   = 4'h2,
        PIU_ST_START = 4'h4,
        PIU_ST_RUN   = 4'h8
    } piu_state_t;

    // ======================================================================
    // Carriers
    // ======================================================================
    typedef struct packed {
        logic       valid;
        logic [7:0] byte9;
    } piu_prm_t;

    typedef struct packed {
        logic       clear;
        logic       add;
        logic [7:0] io_bytes;
    } piu_slave_t;

    typedef struct packed {
        logic [7:0] dig_out;
        logic [7:0] dig_in;
    } piu_chan_t;

    typedef struct packed {
        logic [`PIU_BUDGET_W-1:0] sum;
    } piu_bud_t;

    typedef struct packed {
        piu_state_t            st;
        logic                  prm_ok;
        logic                  sync_mode;
        logic                  fast_mode;
        logic                  pend;
        logic [`PIU_CNT_W-1:0] gap_cnt;
        logic [`PIU_CNT_W-1:0] run_cnt;
        logic [`PIU_CNT_W-1:0] last_run;
        logic [31:0]           est_ns;
    } piu_reg_t;

endpackage
